// file: rtl/rrx_consts.vh
/*
 Constants for the return and rotate execution block: opcode patterns,
 field positions, widths, reset values and cycle counts.
 Assumes 14-bit instruction words and an 8-bit data path.
*/
// Contract
// - interrupt return pops stack into program counter
// - interrupt return sets global interrupt enable
// - interrupt return one word, two cycles, flags kept
// - literal return loads literal into working register
// - literal return pops return address, two cycles
// - plain return pops into counter, two cycles
// - rotate left through carry, only carry changes
// - destination bit zero to W, one to file
// - file operand 0..127 in current bank, one cycle
`ifndef RRX_CONSTS_VH
`define RRX_CONSTS_VH

// instruction word
`define RRX_INSTR_W 14
`define RRX_OP_RETURN 14'h0008
`define RRX_OP_INT_RETURN 14'h0009
`define RRX_OP_MASK 14'h3F00
`define RRX_OP_LIT_RETURN 14'h3400
`define RRX_OP_ROTATE 14'h0D00

// instruction fields
`define RRX_LIT_MSB 7
`define RRX_DEST_BIT 7
`define RRX_FADDR_W 7
`define RRX_FADDR_MSB 6

// data path and status
`define RRX_DATA_W 8
`define RRX_DATA_MSB 7
`define RRX_INT_ENABLE_BIT 7
`define RRX_BANK_W 6

// program counter and stack
`define RRX_PC_W 15
`define RRX_PC_RESET 15'h0000
`define RRX_PC_ONE 15'h0001
`define RRX_W_RESET 8'h00
`define RRX_STACK_DEPTH 16
`define RRX_SP_W 4
`define RRX_SP_RESET 4'h0
`define RRX_SP_ONE 4'h1

// cycles per instruction
`define RRX_RET_CYCLES 2
`define RRX_ROT_CYCLES 1

`endif

// file: rtl/rrx_call_stack.v
/*
 Hardware call stack: flip-flop storage addressed by a stack pointer.
 Assumes push and pop come from logic on the same clock; overflow and
 underflow simply wrap the pointer.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rrx_consts.vh"

module rrx_call_stack #(
   parameter DEPTH = `RRX_STACK_DEPTH,
   parameter SP_W = `RRX_SP_W,
   parameter ADDR_W = `RRX_PC_W
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // push side
   input wire push,
   input wire [ADDR_W-1:0] pushAddr,
   // pop side
   input wire pop,
   output wire [ADDR_W-1:0] topOfStack,
   output reg [SP_W-1:0] stackPtr
);

   reg [ADDR_W-1:0] entry [0:DEPTH-1];
   wire [SP_W-1:0] spDown;
   wire [SP_W-1:0] spUp;

   assign spDown = stackPtr - {{(SP_W-1){1'b0}}, 1'b1};
   assign spUp = stackPtr + {{(SP_W-1){1'b0}}, 1'b1};
   // top entry sits one below the pointer
   assign topOfStack = entry[spDown];

   // pointer moves, pop has priority over push
   always @(posedge clk)
   begin
      if (!rst_n)
         stackPtr <= {SP_W{1'b0}};
      else if (pop)
         stackPtr <= spDown;
      else if (push)
         stackPtr <= spUp;
   end

   // storage written on push only
   always @(posedge clk)
   begin
      if (push && !pop)
         entry[stackPtr] <= pushAddr;
   end

endmodule
`default_nettype wire

// file: rtl/rrx_exec.v
/*
 Execution of return-from-interrupt, return-with-literal, plain return and
 rotate-left-through-carry. Holds the program counter, working register,
 carry and global interrupt enable, and the call stack.
 Assumes the fetch unit, call logic, interrupt entry and file register
 array all run on clk; other instructions merely advance the counter.
 A return leaves one dead cycle in which fetch must drop its prefetch;
 any word offered then is refused and must be held until taken.
 A call push in the same cycle as a return pop is dropped, and a set of
 the interrupt enable by a return wins over a clear in that cycle.
 The file read data must answer fileRdAddr within the same cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rrx_consts.vh"

module rrx_exec #(
   parameter STACK_DEPTH = `RRX_STACK_DEPTH,
   parameter SP_W = `RRX_SP_W,
   parameter PC_W = `RRX_PC_W,
   parameter BANK_W = `RRX_BANK_W
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // instruction from fetch
   input wire [`RRX_INSTR_W-1:0] instrWord,
   input wire instrValid,
   output wire instrTaken,
   output wire flushFetch,
   output reg [PC_W-1:0] pc,
   // call and interrupt entry
   input wire callPush,
   input wire [PC_W-1:0] callAddr,
   input wire globalIntClear,
   // file register array
   input wire [BANK_W-1:0] bankSel,
   output wire [BANK_W+`RRX_FADDR_W-1:0] fileRdAddr,
   input wire [`RRX_DATA_W-1:0] fileRdData,
   output reg fileWrEn,
   output reg [BANK_W+`RRX_FADDR_W-1:0] fileWrAddr,
   output reg [`RRX_DATA_W-1:0] fileWrData,
   // core state
   output reg [`RRX_DATA_W-1:0] wReg,
   output reg carry,
   output reg globalIntEnable,
   output wire [SP_W-1:0] stackPtr
);

   // one-hot states
   localparam [1:0] ST_EXEC = 2'b01;
   localparam [1:0] ST_FLUSH = 2'b10;

   reg [1:0] state;
   reg [1:0] next_state;
   wire [PC_W-1:0] topOfStack;
   wire issue;
   wire isIntReturn;
   wire isLitReturn;
   wire isRotate;
   wire doPop;
   wire rotIssue;
   wire rotToW;
   wire rotToFile;
   wire [`RRX_DATA_W-1:0] rotated;
   wire rotCarry;

   // matches an opcode pattern under the common mask
   function isOp;
      input [`RRX_INSTR_W-1:0] word;
      input [`RRX_INSTR_W-1:0] pattern;
      begin
         isOp = ((word & `RRX_OP_MASK) == pattern);
      end
   endfunction

   // true for any of the three returns
   function isAnyReturn;
      input [`RRX_INSTR_W-1:0] word;
      begin
         isAnyReturn = (word == `RRX_OP_RETURN) || (word == `RRX_OP_INT_RETURN) ||
            isOp(word, `RRX_OP_LIT_RETURN);
      end
   endfunction

   // rotate left through carry: top bit is the carry out
   function [`RRX_DATA_W:0] rotLeftCarry;
      input [`RRX_DATA_W-1:0] value;
      input carryIn;
      begin
         rotLeftCarry = {value, carryIn};
      end
   endfunction

   // handshake towards fetch
   assign instrTaken = (state == ST_EXEC);
   assign flushFetch = (state == ST_FLUSH);
   assign issue = instrValid && (state == ST_EXEC);

   // decode of the four instructions
   assign isIntReturn = (instrWord == `RRX_OP_INT_RETURN);
   assign isLitReturn = isOp(instrWord, `RRX_OP_LIT_RETURN);
   assign isRotate = isOp(instrWord, `RRX_OP_ROTATE); // destination bit 7 lies outside the mask
   assign doPop = issue && isAnyReturn(instrWord);

   // rotate result goes to W or back to the file register
   assign rotIssue = issue && isRotate;
   assign rotToW = rotIssue && !instrWord[`RRX_DEST_BIT];
   assign rotToFile = rotIssue && instrWord[`RRX_DEST_BIT];

   // file operand within the current bank
   assign fileRdAddr = {bankSel, instrWord[`RRX_FADDR_MSB:0]};

   // rotate left through carry
   assign {rotCarry, rotated} = rotLeftCarry(fileRdData, carry);

   // hardware call stack
   rrx_call_stack #(
      .DEPTH(STACK_DEPTH),
      .SP_W(SP_W),
      .ADDR_W(PC_W)
   ) i_rrx_call_stack (
      .clk(clk),
      .rst_n(rst_n),
      .push(callPush),
      .pushAddr(callAddr),
      .pop(doPop),
      .topOfStack(topOfStack),
      .stackPtr(stackPtr)
   );

   // next state: returns take a second, flushing cycle
   always @*
   begin
      next_state = state;
      case (state)
         ST_EXEC:
         begin
            if (doPop)
               next_state = ST_FLUSH;
         end
         ST_FLUSH:
            next_state = ST_EXEC;
         default:
            next_state = ST_EXEC;
      endcase
   end

   // state register
   always @(posedge clk)
   begin
      if (!rst_n)
         state <= ST_EXEC;
      else
         state <= next_state;
   end

   // program counter: popped on returns, else advanced
   always @(posedge clk)
   begin
      if (!rst_n)
         pc <= `RRX_PC_RESET;
      else if (doPop)
         pc <= topOfStack;
      else if (issue)
         pc <= pc + `RRX_PC_ONE;
   end

   // working register: literal return or rotate to W
   always @(posedge clk)
   begin
      if (!rst_n)
         wReg <= `RRX_W_RESET;
      else if (issue && isLitReturn)
         wReg <= instrWord[`RRX_LIT_MSB:0];
      else if (rotToW)
         wReg <= rotated;
   end

   // carry changes on rotate only, returns leave it alone
   always @(posedge clk)
   begin
      if (!rst_n)
         carry <= 1'b0;
      else if (rotIssue)
         carry <= rotCarry;
   end

   // global interrupt enable, set by interrupt return wins over clear
   always @(posedge clk)
   begin
      if (!rst_n)
         globalIntEnable <= 1'b0;
      else if (issue && isIntReturn)
         globalIntEnable <= 1'b1;
      else if (globalIntClear)
         globalIntEnable <= 1'b0;
   end

   // write strobe: one-cycle pulse after a rotate back to the file
   always @(posedge clk)
   begin
      if (!rst_n)
         fileWrEn <= 1'b0;
      else
         fileWrEn <= rotToFile;
   end

   // write address and data captured on every rotate
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         fileWrAddr <= {(BANK_W+`RRX_FADDR_W){1'b0}};
         fileWrData <= `RRX_W_RESET;
      end
      else if (rotIssue)
      begin
         fileWrAddr <= fileRdAddr;
         fileWrData <= rotated;
      end
   end

endmodule
`default_nettype wire

// file: bench/rrx_exec_props.sv
/* checker: port timing of rrx_exec for returns and rotates.
 assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
`include "rrx_consts.vh"
module rrx_exec_props #(parameter PC_W = 15, parameter SP_W = 4, parameter BANK_W = 6) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // fetch side
   input wire [13:0] instrWord,
   input wire instrValid,
   input wire instrTaken,
   input wire flushFetch,
   input wire [PC_W-1:0] pc,
   // file side
   input wire [BANK_W-1:0] bankSel,
   input wire [BANK_W+6:0] fileRdAddr,
   input wire [7:0] fileRdData,
   input wire fileWrEn,
   input wire [BANK_W+6:0] fileWrAddr,
   input wire [7:0] fileWrData,
   // core state
   input wire [7:0] wReg,
   input wire carry,
   input wire globalIntEnable,
   input wire [SP_W-1:0] stackPtr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // decoded accepted instructions
   wire tk = instrValid & instrTaken;
   wire lit = tk & ((instrWord & `RRX_OP_MASK) == `RRX_OP_LIT_RETURN);
   wire ie = tk & (instrWord == `RRX_OP_INT_RETURN);
   wire ret = lit | ie | (tk & (instrWord == `RRX_OP_RETURN));
   wire rot = tk & ((instrWord & `RRX_OP_MASK) == `RRX_OP_ROTATE);
   wire [7:0] rv = {fileRdData[6:0], carry};
   pop_back_a: assert property (ret |=> stackPtr == $past(stackPtr) - 1'b1) else $error("pop");
   flush_once_a: assert property (ret |=> flushFetch && !instrTaken ##1 !flushFetch && instrTaken)
      else $error("flush");
   int_enable_set_a: assert property (ie |=> globalIntEnable) else $error("int enable");
   lit_load_a: assert property (lit |=> wReg == $past(instrWord[7:0])) else $error("lit");
   flags_kept_a: assert property (ret |=> $stable(carry)) else $error("flags");
   rot_carry_a: assert property (rot |=> carry == $past(fileRdData[7])) else $error("carry");
   rot_w_a: assert property (rot && !instrWord[7] |=> wReg == $past(rv) && !fileWrEn)
      else $error("rotw");
   rot_file_a: assert property (rot && instrWord[7] |=> fileWrEn && fileWrData == $past(rv)
      && fileWrAddr == $past(fileRdAddr) && wReg == $past(wReg)) else $error("rotf");
   rot_pc_a: assert property (rot |=> pc == $past(pc) + 1'b1 && instrTaken) else $error("pc");
   rd_addr_a: assert property (fileRdAddr == {bankSel, instrWord[6:0]}) else $error("addr");
   refuse_flush_a: assert property (flushFetch && instrValid |=> $stable(pc) && $stable(wReg)
      && $stable(carry)) else $error("refused");
   ret_c: cover property (ie);
   lit_c: cover property (lit);
   rot_c: cover property (rot && instrWord[7]);
   refuse_c: cover property (flushFetch && instrValid);
endmodule
`default_nettype wire

// file: bench/test_rrx_exec.sv
/* bench: drives rrx_exec at falling edges, checks returns and rotates.
 assumes the constants header on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "rrx_consts.vh"
module test_rrx_exec;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [13:0] instrWord = 14'h0000;
   logic instrValid = 1'b0;
   logic callPush = 1'b0;
   logic [14:0] callAddr = 15'h0000;
   logic globalIntClear = 1'b0;
   logic [5:0] bankSel = 6'h15;
   logic [7:0] fileRdData = 8'h00;
   wire logic instrTaken, flushFetch, fileWrEn, carry, globalIntEnable;
   wire logic [14:0] pc;
   wire logic [12:0] fileRdAddr, fileWrAddr;
   wire logic [7:0] fileWrData, wReg;
   wire logic [3:0] stackPtr;
   logic [14:0] ra [3] = '{15'h0123, 15'h4567, 15'h7FFF};
   logic [13:0] rop [3] = '{14'h0008, 14'h0009, 14'h34FF};
   int fail_count = 0;
   int tests_run = 0;
   rrx_exec i_rrx_exec (.clk, .rst_n, .instrWord, .instrValid, .instrTaken, .flushFetch, .pc, .callPush,
      .callAddr, .globalIntClear, .bankSel, .fileRdAddr, .fileRdData, .fileWrEn, .fileWrAddr, .fileWrData,
      .wReg, .carry, .globalIntEnable, .stackPtr);
   // clock
   initial forever #10 clk = ~clk;
   task chk(input string what, input logic [14:0] exp, input logic [14:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one word through the handshake, ends at the falling edge after it
   task issue(input logic [13:0] w);
      int n;
      @(negedge clk);
      instrWord = w;
      instrValid = 1'b1;
      for (n = 0; instrTaken !== 1'b1; n++)
      begin
         if (n > 4)
         begin
            fail_count++;
            stop_test;
         end
         @(negedge clk);
      end
      @(negedge clk);
      instrValid = 1'b0;
   endtask
   task t_ret;
      for (int i = 0; i < 3; i++)
      begin
         @(negedge clk);
         callPush = 1'b1;
         callAddr = ra[i];
      end
      @(negedge clk);
      callPush = 1'b0;
      globalIntClear = 1'b1;
      @(negedge clk);
      globalIntClear = 1'b0;
      chk("intEnable", 15'h0000, globalIntEnable);
      for (int i = 0; i < 3; i++)
      begin
         issue(rop[i]);
         chk("flush", 15'h0001, {instrTaken, flushFetch});
         chk("pc", ra[2-i], pc);
         chk("sp", 15'(2 - i), stackPtr);
         if (i == 1)
            chk("intEnable", 15'h0001, globalIntEnable);
      end
      chk("w", 15'h00FF, wReg);
      chk("carry", 15'h0000, carry);
      $display("return test done");
   endtask
   task t_rlf;
      fileRdData = 8'hE6;
      issue(14'h0D05);
      chk("w", 15'h00CC, wReg);
      chk("carry", 15'h0001, carry);
      chk("rdaddr", 15'h0A85, fileRdAddr);
      fileRdData = 8'h01;
      issue(14'h0DFF);
      chk("wr", 15'h0103, {fileWrEn, fileWrData});
      chk("wraddr", 15'h0AFF, fileWrAddr);
      chk("w", 15'h00CC, wReg);
      chk("pc", 15'h0125, pc);
      chk("carry", 15'h0000, carry);
      @(negedge clk);
      chk("wren", 15'h0000, fileWrEn);
      $display("rotate test done");
   endtask
   // set of the interrupt enable by a return wins over a clear
   task t_intclr;
      @(negedge clk);
      callPush = 1'b1;
      callAddr = 15'h2222;
      @(negedge clk);
      callPush = 1'b0;
      globalIntClear = 1'b1;
      @(negedge clk);
      chk("intEnable", 15'h0000, globalIntEnable);
      issue(14'h0009);
      chk("intEnable", 15'h0001, globalIntEnable);
      chk("pc", 15'h2222, pc);
      chk("sp", 15'h0000, stackPtr);
      globalIntClear = 1'b0;
      $display("interrupt enable test done");
   endtask
   // a word offered in the dead cycle waits and then runs once
   task t_refuse;
      @(negedge clk);
      callPush = 1'b1;
      callAddr = 15'h0300;
      @(negedge clk);
      callPush = 1'b0;
      fileRdData = 8'hC0;
      instrWord = 14'h0008;
      instrValid = 1'b1;
      @(negedge clk);
      instrWord = 14'h0D05;
      chk("flush", 15'h0001, {instrTaken, flushFetch});
      @(negedge clk);
      chk("pc", 15'h0300, pc);
      chk("carry", 15'h0000, carry);
      @(negedge clk);
      instrValid = 1'b0;
      chk("carry", 15'h0001, carry);
      chk("w", 15'h0080, wReg);
      chk("pc", 15'h0301, pc);
      $display("refuse test done");
   endtask
   // reset in mid-run, then a rotate right after it
   task t_reset;
      @(negedge clk);
      callPush = 1'b1;
      callAddr = 15'h0400;
      @(negedge clk);
      callPush = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk("pc", 15'h0000, pc);
      chk("sp", 15'h0000, stackPtr);
      chk("w", 15'h0000, wReg);
      chk("carry", 15'h0000, carry);
      chk("intEnable", 15'h0000, globalIntEnable);
      chk("flush", 15'h0002, {instrTaken, flushFetch});
      fileRdData = 8'h81;
      issue(14'h0D85);
      chk("wr", 15'h0102, {fileWrEn, fileWrData});
      chk("pc", 15'h0001, pc);
      chk("carry", 15'h0001, carry);
      $display("reset test done");
   endtask
   // main sequence
   initial
   begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      chk("pc", 15'h0000, pc);
      t_ret;
      t_rlf;
      t_intclr;
      t_refuse;
      t_reset;
      stop_test;
   end
endmodule
bind rrx_exec rrx_exec_props #(.PC_W(PC_W), .SP_W(SP_W), .BANK_W(BANK_W)) i_rrx_exec_props (.clk, .rst_n,
   .instrWord, .instrValid, .instrTaken, .flushFetch, .pc, .bankSel, .fileRdAddr, .fileRdData, .fileWrEn,
   .fileWrAddr, .fileWrData, .wReg, .carry, .globalIntEnable, .stackPtr);
`default_nettype wire
